// *** logic/pvi_pkg.sv ***
// Constants, types and helpers shared by the prioritized vector interrupt block
package pvi_pkg;

	// Widths of the register port and the vector path
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int VNUM_W = 6;
	localparam int VBASE_W = 14;
	localparam int ENTRY_SHIFT = 1;
	localparam int VADDR_W = VBASE_W + VNUM_W + ENTRY_SHIFT;
	localparam int TARGET_W = 19;
	localparam int LVL_W = 2;

	// Request sources: three hardware lines, then the software request
	localparam int NUM_HW = 3;
	localparam int NUM_SRC = NUM_HW + 1;
	localparam int IDX_W = 2;
	localparam logic [IDX_W-1:0] SW_IDX = 2'h3;
	localparam logic [VNUM_W-1:0] VEC_FIRST = 6'h3C;

	// Register offsets
	localparam logic [ADDR_W-1:0] REG_PRIO = 4'h0;
	localparam logic [ADDR_W-1:0] REG_VBASE = 4'h1;
	localparam logic [ADDR_W-1:0] REG_CTRL = 4'h2;
	localparam logic [ADDR_W-1:0] REG_STAT = 4'h3;
	localparam logic [ADDR_W-1:0] REG_MASK = 4'h4;
	localparam logic [ADDR_W-1:0] REG_PEND = 4'h5;

	// Field positions in the control register
	localparam int CTRL_LVL_LSB = 0;
	localparam int CTRL_SW_BIT = 2;
	localparam int CTRL_REQ_BIT = 3;
	localparam int CTRL_VEC_LSB = 4;

	// Reset values
	localparam logic [NUM_HW*LVL_W-1:0] PRIO_RST = 6'h00;
	localparam logic [VBASE_W-1:0] VBASE_RST = 14'h0000;
	localparam logic [NUM_SRC-1:0] MASK_RST = 4'h0;

	// Level shown to the core; 00 means nothing or the software request
	typedef enum logic [LVL_W-1:0] {
		PL_NONE_SW = 2'h0,
		PL_0 = 2'h1,
		PL_1 = 2'h2,
		PL_23 = 2'h3
	} pvi_level_e;

	// Presentation states, Gray coded along idle, present, settle
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_PRESENT = 2'h1,
		ST_SETTLE = 2'h3
	} pvi_state_e;

	// Priority field to rank: 00 disabled, 01..11 give levels 0..2
	function automatic logic fieldEnabled(input logic [LVL_W-1:0] fld);
		fieldEnabled = (fld != PL_NONE_SW);
	endfunction : fieldEnabled

	// Rank accepted by the core mask: 00 takes all, else rank above mask
	function automatic logic levelAccepted(input logic [LVL_W-1:0] rank, input logic [LVL_W-1:0] mask);
		levelAccepted = (mask == 2'h0) || (rank > mask);
	endfunction : levelAccepted

endpackage : pvi_pkg

// *** logic/pvi_prio_sel.sv ***
// Combinational winner search over all enabled pending requests
`timescale 1ns/1ps
module pvi_prio_sel
	import pvi_pkg::*;
(
	// Candidate requests
	input wire logic [NUM_SRC-1:0] srcValid,
	input wire logic [NUM_SRC*LVL_W-1:0] srcRank,
	// Winner
	output logic winFound,
	output logic [IDX_W-1:0] winIdx,
	output logic [LVL_W-1:0] winRank
);

	// Running best per stage of the chain
	logic [NUM_SRC:0] stFound;
	logic [IDX_W-1:0] stIdx [NUM_SRC+1];
	logic [LVL_W-1:0] stRank [NUM_SRC+1];

	assign stFound[0] = 1'b0;
	assign stIdx[0] = '0;
	assign stRank[0] = '0;

	// Each stage takes its source only if strictly better, so the lower
	// vector number keeps a tie
	generate
		for (genvar i = 0; i < NUM_SRC; i++)
		begin : g_stage
			logic better;
			assign better = srcValid[i] && (!stFound[i] || (srcRank[i*LVL_W +: LVL_W] > stRank[i]));
			assign stFound[i+1] = stFound[i] || srcValid[i];
			assign stIdx[i+1] = better ? IDX_W'(i) : stIdx[i];
			assign stRank[i+1] = better ? srcRank[i*LVL_W +: LVL_W] : stRank[i];
		end
	endgenerate

	// Final stage is the answer
	assign winFound = stFound[NUM_SRC];
	assign winIdx = stIdx[NUM_SRC];
	assign winRank = stRank[NUM_SRC];

endmodule : pvi_prio_sel

// *** logic/pvi_vector_ctrl.sv ***
// Prioritized vector interrupt controller: registers, selection, core presentation
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module pvi_vector_ctrl
	import pvi_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Register port
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [DATA_W-1:0] regRdata,
	// Peripheral request levels
	input wire logic [NUM_HW-1:0] periphReq,
	// Core side
	input wire logic maskBitHigh,
	input wire logic maskBitLow,
	input wire logic coreAck,
	output logic intReq,
	output logic [VADDR_W-1:0] vectorAddr,
	output logic [LVL_W-1:0] presentedPriorityLevel,
	// Summary interrupt
	output logic irqOut
);

	// How the block behaves, in short:
	// - A hardware line takes part only while its two-bit field is non-zero;
	//   the field value doubles as the rank shown to the core.
	// - The software request carries rank 00, so it is shown only while the
	//   core mask is fully open, below every hardware level.
	// - While a vector stands the choice is remade every cycle; a stronger
	//   arrival replaces it before the core takes it, which is how nesting
	//   is offered to the core.
	// - After the core takes a vector the request drops for two cycles, so
	//   the core can raise its mask before the next choice is made.
	// - Rank 11 is priority 2; priority 3 is never produced here, so a fully
	//   raised mask silences the block until software lowers it.
	// - The base is 14 bits and the vector number 6 bits; with the zero word
	//   appended each vector address is a 21-bit word address, and with the
	//   base at its reset value the table starts at word zero.
	// - Each taken vector sets a sticky status bit; the summary output is
	//   high while an unmasked status bit is set.
	// - Hazard: a base written while a vector stands changes the address
	//   shown on the next cycle, before the core has taken it.

	// Software-written state
	logic [NUM_HW*LVL_W-1:0] prioField; // Per-source priority fields
	logic [VBASE_W-1:0] vectorBase; // Table base
	logic swPend; // Low-priority software request
	logic [NUM_SRC-1:0] evtStat; // Sticky taken-events
	logic [NUM_SRC-1:0] evtMask; // Event mask
	logic [NUM_HW*LVL_W-1:0] next_prioField;
	logic [VBASE_W-1:0] next_vectorBase;
	logic next_swPend;
	logic [NUM_SRC-1:0] next_evtStat;
	logic [NUM_SRC-1:0] next_evtMask;
	logic [DATA_W-1:0] next_regRdata;
	logic next_irqOut;

	// Presentation state
	pvi_state_e state;
	pvi_state_e next_state;
	logic [IDX_W-1:0] presIdx; // Source now shown to the core
	logic [IDX_W-1:0] next_presIdx;
	logic next_intReq;
	logic [VADDR_W-1:0] next_vectorAddr;
	logic [LVL_W-1:0] next_presentedPriorityLevel;

	// Selection results
	logic [NUM_SRC-1:0] srcValid;
	logic [NUM_SRC*LVL_W-1:0] srcRank;
	logic winFound;
	logic [IDX_W-1:0] winIdx;
	logic [LVL_W-1:0] winRank;
	logic [LVL_W-1:0] coreMask; // Status bits 9 and 8 of the core
	logic winAccepted;
	logic [VNUM_W-1:0] winVnum;
	logic ackTaken; // Core took the presented vector

	// Write decode, one strobe per writable register
	logic wrPrio; // Priority fields written
	logic wrVbase; // Table base written
	logic wrCtrl; // Control written
	logic wrStat; // Status clear written
	logic wrMask; // Event mask written

	// Vector number of a source: sources follow the first vector in order
	function automatic logic [VNUM_W-1:0] vectorNumber(input logic [IDX_W-1:0] idx);
		vectorNumber = VNUM_W'(VEC_FIRST + VNUM_W'(idx));
	endfunction : vectorNumber

	// Build candidate list; hardware lines need a non-zero field
	generate
		for (genvar i = 0; i < NUM_HW; i++)
		begin : g_src
			assign srcValid[i] = periphReq[i] && fieldEnabled(prioField[i*LVL_W +: LVL_W]);
			assign srcRank[i*LVL_W +: LVL_W] = prioField[i*LVL_W +: LVL_W];
		end
	endgenerate

	// Software request ranks below every hardware level
	assign srcValid[SW_IDX] = swPend;
	assign srcRank[SW_IDX*LVL_W +: LVL_W] = PL_NONE_SW;

	// Winner search; ties keep the lower vector number, so the choice
	// never depends on which line rose first within a cycle
	pvi_prio_sel u_sel (
		.srcValid(srcValid),
		.srcRank(srcRank),
		.winFound(winFound),
		.winIdx(winIdx),
		.winRank(winRank)
	);

	// Core mask gates what may be shown; a raised mask admits only higher
	// levels, which is what lets a stronger request nest
	assign coreMask = {maskBitHigh, maskBitLow};
	assign winAccepted = winFound && levelAccepted(winRank, coreMask);
	assign winVnum = vectorNumber(winIdx);
	assign ackTaken = (state == ST_PRESENT) && coreAck;

	// One strobe per writable offset; pending and unmapped offsets write nothing
	assign wrPrio = regWr && (regAddr == REG_PRIO);
	assign wrVbase = regWr && (regAddr == REG_VBASE);
	assign wrCtrl = regWr && (regAddr == REG_CTRL);
	assign wrStat = regWr && (regAddr == REG_STAT);
	assign wrMask = regWr && (regAddr == REG_MASK);

	// Register group: next values
	always_comb
	begin
		// Hold every field unless a write or an event changes it
		next_prioField = prioField;
		next_vectorBase = vectorBase;
		next_swPend = swPend;
		next_evtStat = evtStat;
		next_evtMask = evtMask;
		next_regRdata = '0;
		// Writes; each writable register has its own strobe
		if (wrPrio)
		begin
			// Field 00 keeps the line out of the choice
			next_prioField = regWdata[NUM_HW*LVL_W-1:0];
		end
		if (wrVbase)
		begin
			// New base applies to the next vector formed
			next_vectorBase = regWdata[VBASE_W-1:0];
		end
		if (wrStat)
		begin
			// Write one to clear
			next_evtStat = evtStat & ~regWdata[NUM_SRC-1:0];
		end
		if (wrMask)
		begin
			next_evtMask = regWdata[NUM_SRC-1:0];
		end
		// Software request cleared when taken; a new write wins
		if (ackTaken && (presIdx == SW_IDX))
		begin
			next_swPend = 1'b0;
		end
		if (wrCtrl && regWdata[CTRL_SW_BIT])
		begin
			next_swPend = 1'b1;
		end
		// Taken event sets its sticky bit, over any clear
		if (ackTaken)
		begin
			next_evtStat[presIdx] = 1'b1;
		end
		// Read data stand in the next cycle only; unmapped reads give zero
		if (regRd)
		begin
			case (regAddr)
				REG_PRIO: next_regRdata = DATA_W'(prioField);
				REG_VBASE: next_regRdata = DATA_W'(vectorBase);
				REG_CTRL:
				begin
					next_regRdata[CTRL_LVL_LSB +: LVL_W] = presentedPriorityLevel;
					next_regRdata[CTRL_SW_BIT] = swPend;
					next_regRdata[CTRL_REQ_BIT] = intReq;
					next_regRdata[CTRL_VEC_LSB +: VNUM_W] = vectorNumber(presIdx);
				end
				REG_STAT: next_regRdata = DATA_W'(evtStat);
				REG_MASK: next_regRdata = DATA_W'(evtMask);
				REG_PEND: next_regRdata = DATA_W'(srcValid);
				default: next_regRdata = '0;
			endcase
		end
		// Summary output follows the values about to be stored
		next_irqOut = |(next_evtStat & next_evtMask);
	end

	// Register group: storage
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			// All lines disabled, base at its reset value
			prioField <= PRIO_RST;
			vectorBase <= VBASE_RST;
			swPend <= 1'b0;
			evtStat <= '0;
			evtMask <= MASK_RST;
			regRdata <= '0;
			irqOut <= 1'b0;
		end
		else
		begin
			// Take the computed values every cycle
			prioField <= next_prioField;
			vectorBase <= next_vectorBase;
			swPend <= next_swPend;
			evtStat <= next_evtStat;
			evtMask <= next_evtMask;
			regRdata <= next_regRdata;
			irqOut <= next_irqOut;
		end
	end

	// Presentation group: next values; while presenting the choice is
	// re-made every cycle so a stronger arrival replaces the current one
	always_comb
	begin
		next_state = state;
		next_presIdx = presIdx;
		next_intReq = 1'b0;
		next_vectorAddr = vectorAddr;
		next_presentedPriorityLevel = PL_NONE_SW;
		case (state)
			ST_IDLE, ST_PRESENT:
			begin
				if (ackTaken)
				begin
					// Give the core one cycle to raise its mask
					next_state = ST_SETTLE;
				end
				else if (winAccepted)
				begin
					next_state = ST_PRESENT;
					next_presIdx = winIdx;
					next_intReq = 1'b1;
					// Base joined to number, entries two words apart, word units
					next_vectorAddr = {vectorBase, winVnum, 1'b0};
					next_presentedPriorityLevel = winRank;
				end
				else
				begin
					// Nothing acceptable: stand down
					next_state = ST_IDLE;
				end
			end
			ST_SETTLE:
			begin
				// Mask had its cycle to change; choose again
				next_state = ST_IDLE;
			end
			default:
			begin
				// Unused code goes back to idle
				next_state = ST_IDLE;
			end
		endcase
	end

	// Presentation group: storage
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			// Nothing presented after reset
			state <= ST_IDLE;
			presIdx <= '0;
			intReq <= 1'b0;
			vectorAddr <= '0;
			presentedPriorityLevel <= PL_NONE_SW;
		end
		else
		begin
			// Register the presentation every cycle
			state <= next_state;
			presIdx <= next_presIdx;
			intReq <= next_intReq;
			vectorAddr <= next_vectorAddr;
			presentedPriorityLevel <= next_presentedPriorityLevel;
		end
	end

endmodule : pvi_vector_ctrl

// *** verif/pvi_vector_checker.sv ***
// Checker of the core-side outputs of the vector controller
`timescale 1ns/1ps
module pvi_vector_checker
	import pvi_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Core side
	input wire logic maskBitHigh,
	input wire logic maskBitLow,
	input wire logic coreAck,
	input wire logic intReq,
	input wire logic [VADDR_W-1:0] vectorAddr,
	input wire logic [LVL_W-1:0] presentedPriorityLevel
);
	// Core mask as one field
	logic [1:0] coreMask;
	assign coreMask = {maskBitHigh, maskBitLow};
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	property p_lsb; vectorAddr[0] == 1'b0; endproperty
	a_lsb: assert property (p_lsb) else $error("odd vector address");
	property p_vnum; intReq |-> vectorAddr[6:3] == 4'hF; endproperty
	a_vnum: assert property (p_vnum) else $error("vector outside table");
	property p_sw; intReq && vectorAddr[6:1] == 6'h3F |-> presentedPriorityLevel == 2'h0; endproperty
	a_sw: assert property (p_sw) else $error("software level wrong");
	property p_hw; intReq && vectorAddr[6:1] != 6'h3F |-> presentedPriorityLevel != 2'h0; endproperty
	a_hw: assert property (p_hw) else $error("hardware level missing");
	property p_idle; !intReq |-> presentedPriorityLevel == 2'h0; endproperty
	a_idle: assert property (p_idle) else $error("level shown while idle");
	property p_top; presentedPriorityLevel == 2'h3 |-> intReq && vectorAddr[6:1] != 6'h3F; endproperty
	a_top: assert property (p_top) else $error("top level without hardware vector");
	property p_mask; intReq && $past(coreMask) != 2'h0 |-> presentedPriorityLevel > $past(coreMask); endproperty
	a_mask: assert property (p_mask) else $error("masked level shown");
	property p_ack; coreAck && intReq |=> !intReq [*2]; endproperty
	a_ack: assert property (p_ack) else $error("request held after ack");
endmodule : pvi_vector_checker
bind pvi_vector_ctrl pvi_vector_checker u_chk (.mclk, .rst_n, .maskBitHigh, .maskBitLow, .coreAck, .intReq,
	.vectorAddr, .presentedPriorityLevel);

// *** verif/pvi_core_model.sv ***
// Behavioural core that takes presented vectors and masks levels
`timescale 1ns/1ps
module pvi_core_model
	import pvi_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Bench controls
	input wire logic ackOn,
	input wire logic clrMask,
	// Controller side
	input wire logic intReq,
	input wire logic [LVL_W-1:0] presentedPriorityLevel,
	output logic coreAck,
	output logic maskBitHigh,
	output logic maskBitLow
);
	// Cycles spent on the current request
	logic [1:0] dly;
	// Ack three cycles late, then mask up to the level taken
	always_ff @(posedge mclk)
	begin
		if (!rst_n || clrMask)
		begin
			coreAck <= 1'b0;
			{maskBitHigh, maskBitLow} <= 2'h0;
			dly <= 2'h0;
		end
		else if (coreAck)
		begin
			coreAck <= 1'b0;
			{maskBitHigh, maskBitLow} <= presentedPriorityLevel;
			dly <= 2'h0;
		end
		else if (intReq && ackOn)
		begin
			dly <= dly + 2'h1;
			coreAck <= (dly == 2'h2);
		end
		else
			dly <= 2'h0;
	end
endmodule : pvi_core_model

// *** verif/pvi_vector_ctrl_tb.sv ***
// Self-checking bench for the vector controller
`timescale 1ns/1ps
module pvi_vector_ctrl_tb
	import pvi_pkg::*;
;
	// Drive and observed signals
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic ackOn = 1'b0;
	logic clrMask = 1'b0;
	logic coreAck, maskBitHigh, maskBitLow, intReq, irqOut;
	logic [ADDR_W-1:0] regAddr = '0;
	logic [DATA_W-1:0] regWdata = '0;
	logic [DATA_W-1:0] regRdata;
	logic [NUM_HW-1:0] periphReq = '0;
	logic [VADDR_W-1:0] vectorAddr;
	logic [LVL_W-1:0] lvl;
	int err_count = 0;
	int cmp_count = 0;
	// 200 MHz clock
	always #2.5 mclk = ~mclk;
	pvi_vector_ctrl u_dut (.mclk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .periphReq,
		.maskBitHigh, .maskBitLow, .coreAck, .intReq, .vectorAddr, .presentedPriorityLevel(lvl), .irqOut);
	pvi_core_model u_core (.mclk, .rst_n, .ackOn, .clrMask, .intReq, .presentedPriorityLevel(lvl),
		.coreAck, .maskBitHigh, .maskBitLow);
	// Compare one value
	task automatic cmp(input string n, input logic [VADDR_W-1:0] e, input logic [VADDR_W-1:0] g);
		cmp_count++;
		if (g !== e)
		begin
			err_count++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask : cmp
	// One-cycle register write
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask : wr
	// Read, data checked in the following cycle
	task automatic rd(input string n, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		@(posedge mclk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		#1 cmp(n, e, regRdata);
	endtask : rd
	// Wait for a presented vector and check it
	task automatic wq(input logic [VADDR_W-1:0] a, input logic [LVL_W-1:0] l);
		#1;
		repeat (40) if (intReq !== 1'b1) @(posedge mclk) #1;
		cmp("req", 1'b1, intReq);
		cmp("vec", a, vectorAddr);
		cmp("lvl", l, lvl);
	endtask : wq
	// Verdict
	task automatic end_sim;
		if (err_count == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	// Hang guard
	initial
	begin
		#20000;
		err_count++;
		end_sim();
	end
	// Main sequence
	initial
	begin
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		rd("prio", REG_PRIO, 16'h0000);
		rd("base", REG_VBASE, 16'h0000);
		rd("hole", 4'hF, 16'h0000);
		@(posedge mclk) periphReq <= 3'h7;
		repeat (3) @(posedge mclk);
		#1 cmp("off", 1'b0, intReq);
		@(posedge mclk) periphReq <= 3'h0;
		wr(REG_PRIO, 16'h0039);
		wr(REG_MASK, 16'h000F);
		@(posedge mclk) periphReq <= 3'h1;
		wq(21'h00078, 2'h1);
		@(posedge mclk) periphReq <= 3'h3;
		repeat (3) @(posedge mclk);
		wq(21'h0007A, 2'h2);
		rd("pend", REG_PEND, 16'h0003);
		@(posedge mclk) ackOn <= 1'b1;
		repeat (10) @(posedge mclk);
		#1 cmp("masked", 1'b0, intReq);
		@(posedge mclk) periphReq <= 3'h7;
		wq(21'h0007C, 2'h3);
		repeat (8) @(posedge mclk);
		#1 cmp("irq", 1'b1, irqOut);
		rd("stat", REG_STAT, 16'h0006);
		wr(REG_MASK, 16'h0001);
		rd("mask", REG_MASK, 16'h0001);
		cmp("irqmask", 1'b0, irqOut);
		wr(REG_STAT, 16'h0006);
		@(posedge mclk) periphReq <= 3'h0;
		clrMask <= 1'b1;
		ackOn <= 1'b0;
		@(posedge mclk) clrMask <= 1'b0;
		#1 cmp("irq", 1'b0, irqOut);
		wr(REG_PRIO, 16'h0015);
		@(posedge mclk) periphReq <= 3'h7;
		wq(21'h00078, 2'h1);
		wr(REG_VBASE, 16'h0400);
		@(posedge mclk) periphReq <= 3'h4;
		repeat (3) @(posedge mclk);
		wq({14'h0400, 6'h3E, 1'b0}, 2'h1);
		@(posedge mclk) periphReq <= 3'h0;
		repeat (4) @(posedge mclk);
		wr(REG_CTRL, 16'h0004);
		wq({14'h0400, 6'h3F, 1'b0}, 2'h0);
		rd("ctrl", REG_CTRL, 16'h03FC);
		@(posedge mclk) ackOn <= 1'b1;
		repeat (8) @(posedge mclk);
		rd("stat", REG_STAT, 16'h0008);
		end_sim();
	end
endmodule : pvi_vector_ctrl_tb
